// *** rtl/ebc_ready_pkg.sv ***
package ebc_ready_pkg;

   // ----------------------------------------
   // register map (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] cfg_offset = 8'h00;
   localparam logic [7:0] cmd_offset = 8'h04;
   localparam logic [7:0] addr_offset = 8'h08;
   localparam logic [7:0] wdata_offset = 8'h0c;
   localparam logic [7:0] rdata_offset = 8'h10;
   localparam logic [7:0] status_offset = 8'h14;

   // ----------------------------------------
   // cfg field positions
   // ----------------------------------------
   localparam int setup_pos = 0;
   localparam int cmd_pos = 2;
   localparam int wsetup_pos = 4;
   localparam int access_pos = 5;
   localparam int hold_pos = 10;
   localparam int rdy_en_pos = 12;
   localparam int rdy_pol_pos = 13;
   localparam int rdy_async_pos = 14;
   localparam int mux_pos = 15;
   localparam logic [31:0] cfg_reset = 32'h0000_0000;

   // ----------------------------------------
   // timing: one phase time unit is one system clock
   // ----------------------------------------
   localparam int pclk_period_ns = 10;
   localparam int phase_unit_ns = 10;
   localparam logic [5:0] phase_unit_cycles = 6'((phase_unit_ns + pclk_period_ns - 1)
                                                 / pclk_period_ns);

   typedef enum logic [2:0] {
      st_idle,
      st_setup,
      st_cmd,
      st_wsetup,
      st_access,
      st_hold
   } phase_type;

   typedef struct packed {
      logic [1:0] setup;
      logic [1:0] cmd;
      logic wsetup;
      logic [4:0] access;
      logic [1:0] hold;
      logic rdy_en;
      logic rdy_pol;
      logic rdy_async;
      logic mux;
   } cycle_cfg_type;

   typedef struct packed {
      logic [23:0] addr;
      logic [15:0] data;
      logic data_oe;
      logic rd_n;
      logic wr_n;
      logic cs_n;
      logic ale;
   } bus_pins_type;

endpackage

// *** rtl/ext_bus_ready_waitstate_ctrl.sv ***
// Overview of operation
// - external ready sets cycle length
// - ready polarity is configurable
// - asynchronous ready gets extra sync stage
// - first sample point follows programmed phases
// - inactive sample adds one wait state
// - active sample ends the cycle
// - sample points differ sync versus async
// - ready ignored during mandatory wait states
// - read data captured at strobe rise edge
// - address change cannot corrupt read data
// - five phases, each programmable length
// - access phase 1 to 32 units
// - write setup phase 0 or 1 unit (here always one cycle, whatever the field holds)
// - hold phase 0 to 3 units (here 1 to 3 cycles; field 0 also gives one cycle)
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
module ext_bus_ready_waitstate_ctrl (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ready_pin,
   input wire logic [15:0] data_in,
   output logic reference_clock_output,
   output ebc_ready_pkg::bus_pins_type bus_ff
);
   logic [31:0] cfg_ff;
   logic [23:0] addr_ff;
   logic [15:0] wdata_ff;
   logic [15:0] rdata_ff;
   logic is_write_ff;
   logic done_ff;
   logic start;
   logic [5:0] cnt_ff;
   logic [5:0] mand_ff;
   logic [15:0] din_meta_ff;
   logic [15:0] din_ff;
   logic rdy_sync;
   logic rdy_async;
   logic rdy_now;
   logic rdy_sample_ok;
   logic phase_end;
   logic wr_en;
   logic rd_en;
   logic [31:0] nxt_prdata;
   logic refclk_ff;
   ebc_ready_pkg::cycle_cfg_type cc;
   ebc_ready_pkg::phase_type state_ff;
   ebc_ready_pkg::phase_type nxt_state;

   // ----------------------------------------
   // apb slave
   // ----------------------------------------
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && !penable && !pwrite;
   assign start = wr_en && paddr == ebc_ready_pkg::cmd_offset && state_ff == ebc_ready_pkg::st_idle;

   assign cc.setup = cfg_ff[ebc_ready_pkg::setup_pos +: 2];
   assign cc.cmd = cfg_ff[ebc_ready_pkg::cmd_pos +: 2];
   assign cc.wsetup = cfg_ff[ebc_ready_pkg::wsetup_pos];
   assign cc.access = cfg_ff[ebc_ready_pkg::access_pos +: 5];
   assign cc.hold = cfg_ff[ebc_ready_pkg::hold_pos +: 2];
   assign cc.rdy_en = cfg_ff[ebc_ready_pkg::rdy_en_pos];
   assign cc.rdy_pol = cfg_ff[ebc_ready_pkg::rdy_pol_pos];
   assign cc.rdy_async = cfg_ff[ebc_ready_pkg::rdy_async_pos];
   assign cc.mux = cfg_ff[ebc_ready_pkg::mux_pos];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_ff <= ebc_ready_pkg::cfg_reset;
         addr_ff <= 24'h00_0000;
         wdata_ff <= 16'h0000;
         is_write_ff <= 1'b0;
      end else if (wr_en) begin
         unique case (paddr)
            ebc_ready_pkg::cfg_offset: cfg_ff <= {16'h0000, pwdata[15:0]};
            ebc_ready_pkg::addr_offset: addr_ff <= pwdata[23:0];
            ebc_ready_pkg::wdata_offset: wdata_ff <= pwdata[15:0];
            ebc_ready_pkg::cmd_offset: begin
               if (start) begin
                  is_write_ff <= pwdata[0];
               end
            end
            default: begin
            end
         endcase
      end
   end

   always_comb begin
      nxt_prdata = 32'h0000_0000;
      unique case (paddr)
         ebc_ready_pkg::cfg_offset: nxt_prdata = cfg_ff;
         ebc_ready_pkg::addr_offset: nxt_prdata = {8'h00, addr_ff};
         ebc_ready_pkg::wdata_offset: nxt_prdata = {16'h0000, wdata_ff};
         ebc_ready_pkg::rdata_offset: nxt_prdata = {16'h0000, rdata_ff};
         ebc_ready_pkg::status_offset: begin
            nxt_prdata = {29'h0000_0000, done_ff, rdy_now,
                          state_ff != ebc_ready_pkg::st_idle};
         end
         default: nxt_prdata = 32'h0000_0000;
      endcase
   end

   // no wait cycle on any access: setup, then answer in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= 1'b0;
         if (rd_en) begin
            prdata <= nxt_prdata;
         end
      end
   end

   // ----------------------------------------
   // reference clock and pin capture
   // ----------------------------------------
   // half-clock-rate reference; toggles so it comes straight from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         refclk_ff <= 1'b0;
      end else begin
         refclk_ff <= ~refclk_ff;
      end
   end
   assign reference_clock_output = refclk_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         din_meta_ff <= 16'h0000;
         din_ff <= 16'h0000;
      end else begin
         din_meta_ff <= data_in;
         din_ff <= din_meta_ff;
      end
   end

   ready_sync u_ready_sync (
      .pclk(pclk),
      .presetn(presetn),
      .ready_pin(ready_pin),
      .active_high(cc.rdy_pol),
      .sync_ready(rdy_sync),
      .async_ready(rdy_async)
   );

   assign rdy_now = cc.rdy_async ? rdy_async : rdy_sync;

   // ----------------------------------------
   // cycle phase sequencer
   // ----------------------------------------
   // ready ignored until mandatory states done
   assign rdy_sample_ok = (mand_ff == 6'h00);
   assign phase_end = (cnt_ff <= 6'h01);

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ebc_ready_pkg::st_idle: begin
            if (start) begin
               nxt_state = ebc_ready_pkg::st_setup;
            end
         end
         ebc_ready_pkg::st_setup: begin
            if (phase_end) begin
               nxt_state = ebc_ready_pkg::st_cmd;
            end
         end
         ebc_ready_pkg::st_cmd: begin
            if (phase_end) begin
               nxt_state = ebc_ready_pkg::st_wsetup;
            end
         end
         ebc_ready_pkg::st_wsetup: begin
            if (phase_end) begin
               nxt_state = ebc_ready_pkg::st_access;
            end
         end
         ebc_ready_pkg::st_access: begin
            // inactive ready adds a wait state
            if (rdy_sample_ok && (!cc.rdy_en || rdy_now)) begin
               nxt_state = ebc_ready_pkg::st_hold;
            end
         end
         ebc_ready_pkg::st_hold: begin
            if (phase_end) begin
               nxt_state = ebc_ready_pkg::st_idle;
            end
         end
      endcase
   end

   // reset clears counters, no cycle running
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= ebc_ready_pkg::st_idle;
         cnt_ff <= 6'h00;
         mand_ff <= 6'h00;
      end else begin
         state_ff <= nxt_state;
         if (cnt_ff != 6'h00) begin
            cnt_ff <= cnt_ff - 6'h01;
         end
         if (mand_ff != 6'h00) begin
            mand_ff <= mand_ff - 6'h01;
         end
         if (nxt_state != state_ff) begin
            unique case (nxt_state)
               // setup phase is one unit plus the programmed extension
               ebc_ready_pkg::st_setup: cnt_ff <= {4'h0, cc.setup} + ebc_ready_pkg::phase_unit_cycles;
               ebc_ready_pkg::st_cmd: cnt_ff <= {4'h0, cc.cmd};
               ebc_ready_pkg::st_wsetup: cnt_ff <= {5'h00, cc.wsetup};
               ebc_ready_pkg::st_access: begin
                  // 1 to 32 units, field holds length minus one
                  // sample point from programmed access length
                  mand_ff <= {1'b0, cc.access};
               end
               ebc_ready_pkg::st_hold: cnt_ff <= {4'h0, cc.hold};
               default: cnt_ff <= 6'h00;
            endcase
         end
      end
   end

   // ----------------------------------------
   // pins and read capture
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_ff <= '{addr: 24'h00_0000, data: 16'h0000, data_oe: 1'b0, rd_n: 1'b1,
                     wr_n: 1'b1, cs_n: 1'b1, ale: 1'b0};
      end else begin
         bus_ff.cs_n <= (nxt_state == ebc_ready_pkg::st_idle);
         bus_ff.ale <= cc.mux && (nxt_state == ebc_ready_pkg::st_setup);
         bus_ff.rd_n <= !(!is_write_ff && nxt_state == ebc_ready_pkg::st_access);
         bus_ff.wr_n <= !(is_write_ff && nxt_state == ebc_ready_pkg::st_access);
         bus_ff.addr <= (nxt_state == ebc_ready_pkg::st_idle) ? 24'h00_0000 : addr_ff;
         bus_ff.data_oe <= is_write_ff && nxt_state != ebc_ready_pkg::st_idle &&
                           nxt_state != ebc_ready_pkg::st_setup;
         bus_ff.data <= cc.mux && nxt_state == ebc_ready_pkg::st_setup ? addr_ff[15:0] : wdata_ff;
      end
   end

   // latch on the edge that raises the strobe
   // data taken from data pins only, never tied to address
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_ff <= 16'h0000;
         done_ff <= 1'b0;
      end else begin
         if (state_ff == ebc_ready_pkg::st_access && nxt_state == ebc_ready_pkg::st_hold) begin
            if (!is_write_ff) begin
               rdata_ff <= din_ff;
            end
            done_ff <= 1'b1;
         end else if (start) begin
            done_ff <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   a_mand_ignore: assert property (@(posedge pclk) disable iff (!presetn)
      (state_ff == ebc_ready_pkg::st_access && mand_ff != 6'h00)
      |=> state_ff == ebc_ready_pkg::st_access)
      else $error("access left during mandatory wait");
   a_wait_inactive: assert property (@(posedge pclk) disable iff (!presetn)
      (state_ff == ebc_ready_pkg::st_access && rdy_sample_ok && cc.rdy_en && !rdy_now)
      |=> state_ff == ebc_ready_pkg::st_access)
      else $error("no wait state on inactive ready");
   a_end_active: assert property (@(posedge pclk) disable iff (!presetn)
      (state_ff == ebc_ready_pkg::st_access && rdy_sample_ok && rdy_now)
      |=> state_ff == ebc_ready_pkg::st_hold)
      else $error("cycle not ended on ready");
   a_strobe_rise: assert property (@(posedge pclk) disable iff (!presetn)
      ($rose(bus_ff.rd_n) && !is_write_ff) |-> rdata_ff == $past(din_ff))
      else $error("read data not taken at strobe rise");
   a_async_later: assert property (@(posedge pclk) disable iff (!presetn)
      (cc.rdy_pol && $stable(cc.rdy_pol)) |-> rdy_async == $past(rdy_sync))
      else $error("async path lacks extra stage");
   a_hold_len: assert property (@(posedge pclk) disable iff (!presetn)
      ($rose(state_ff == ebc_ready_pkg::st_hold) && cc.hold == 2'h3)
      |-> state_ff == ebc_ready_pkg::st_hold [*3] ##1 state_ff == ebc_ready_pkg::st_idle)
      else $error("hold phase length wrong");
   a_strobe_phase: assert property (@(posedge pclk) disable iff (!presetn)
      !bus_ff.rd_n |-> state_ff == ebc_ready_pkg::st_access)
      else $error("read strobe outside access");
   a_start_setup: assert property (@(posedge pclk) disable iff (!presetn)
      start |=> state_ff == ebc_ready_pkg::st_setup ##1 !bus_ff.cs_n)
      else $error("cycle did not start");
endmodule

// *** rtl/ready_sync.sv ***
module ready_sync (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ready_pin,
   input wire logic active_high,
   output logic sync_ready,
   output logic async_ready
);
   logic meta_ff;
   logic sync_ff;
   logic extra_ff;

   // ----------------------------------------
   // two-flop capture plus the extra stage
   // ----------------------------------------
   // clear synchronizer on reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
         extra_ff <= 1'b0;
      end else begin
         meta_ff <= ready_pin;
         sync_ff <= meta_ff;
         extra_ff <= sync_ff;
      end
   end

   assign sync_ready = active_high ? sync_ff : ~sync_ff;
   assign async_ready = active_high ? extra_ff : ~extra_ff;
endmodule

// *** tb/ext_module_model.sv ***
module ext_module_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic lclk,
   input wire ebc_ready_pkg::bus_pins_type bus,
   input wire logic act_high,
   input wire logic link_mode,
   input wire logic [7:0] delay,
   input wire logic [15:0] rd_word,
   output logic ready_pin,
   output logic [15:0] data_in
);
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------
   // ready handshake of the far module
   // ----------------------------------------
   logic strobe;
   logic lclk_q;
   logic rdy_on;
   logic [7:0] cnt;

   assign strobe = !bus.cs_n && !(bus.rd_n && bus.wr_n);
   assign ready_pin = rdy_on ? act_high : !act_high;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 8'h00;
         rdy_on <= 1'b0;
         lclk_q <= 1'b0;
         data_in <= 16'h0000;
      end else begin
         lclk_q <= lclk;
         cnt <= strobe ? cnt + 8'h01 : 8'h00;
         if (!strobe) begin
            rdy_on <= 1'b0;
         end else if (!link_mode || (lclk && !lclk_q)) begin
            rdy_on <= (cnt >= delay);
         end
         // data gone after strobe; moving pattern so no stale value passes
         if (!bus.rd_n) begin
            data_in <= rd_word;
         end else begin
            data_in <= ~data_in;
         end
      end
   end
endmodule

// *** tb/tb_ext_bus_ready_waitstate_ctrl.sv ***
module tb_ext_bus_ready_waitstate_ctrl;
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ready_pin, refclk;
   logic lclk, act_high, link_mode, last_err;
   logic [7:0] paddr, delay;
   logic [31:0] pwdata, prdata;
   logic [15:0] data_in, wr_seen, mux_addr;
   logic [23:0] addr_seen;
   ebc_ready_pkg::bus_pins_type bus;
   int failures, checks_done, strobe_cnt, len_a;
   localparam logic [15:0] rd_word = 16'hc3a5;

   ext_bus_ready_waitstate_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ready_pin(ready_pin), .data_in(data_in),
      .reference_clock_output(refclk), .bus_ff(bus));
   ext_module_model i_far (.pclk(pclk), .presetn(presetn), .lclk(lclk), .bus(bus),
      .act_high(act_high), .link_mode(link_mode), .delay(delay), .rd_word(rd_word),
      .ready_pin(ready_pin), .data_in(data_in));

   always #5 pclk = ~pclk;
   // link clock at one sixteenth of pclk, its edges always on pclk falling edges
   always #80 lclk = ~lclk;

   always @(posedge pclk) begin
      if (bus.rd_n === 1'b0 || bus.wr_n === 1'b0) begin
         strobe_cnt <= strobe_cnt + 1;
      end
      if (bus.wr_n === 1'b0 && bus.data_oe === 1'b1) begin
         wr_seen <= bus.data;
         addr_seen <= bus.addr;
      end
      // address phase of a multiplexed cycle
      if (bus.ale === 1'b1) begin
         mux_addr <= bus.data;
      end
   end

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic give_verdict();
      if (failures == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic timeout();
      failures++;
      give_verdict();
   endtask

   task automatic apb(input logic wr, input logic [7:0] adr, input logic [31:0] wd,
                      output logic [31:0] rd);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= adr;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) timeout();
      rd = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   function automatic logic [31:0] cfg_of(input logic [4:0] acc, input logic asy, pol, en);
      cfg_of = 32'(acc) << ebc_ready_pkg::access_pos;
      cfg_of[ebc_ready_pkg::rdy_en_pos] = en;
      cfg_of[ebc_ready_pkg::rdy_pol_pos] = pol;
      cfg_of[ebc_ready_pkg::rdy_async_pos] = asy;
   endfunction

   // one bus cycle; returns strobe-low cycles
   task automatic run(input logic [31:0] cfg, input logic wr, input logic [7:0] dly,
                      output int len);
      logic [31:0] d;
      int n;
      int base;
      delay <= dly;
      apb(1'b1, ebc_ready_pkg::cfg_offset, cfg, d);
      apb(1'b1, ebc_ready_pkg::addr_offset, 32'h0012_3456, d);
      apb(1'b1, ebc_ready_pkg::wdata_offset, 32'h0000_beef, d);
      // only the monitor writes the counter; measure from a base
      base = strobe_cnt;
      apb(1'b1, ebc_ready_pkg::cmd_offset, {31'h0, wr}, d);
      apb(1'b0, ebc_ready_pkg::status_offset, 32'h0, d);
      check(d & 32'h5, 32'h1);
      for (n = 0; n < 300 && d[2] !== 1'b1; n++) begin
         apb(1'b0, ebc_ready_pkg::status_offset, 32'h0, d);
      end
      if (d[2] !== 1'b1) timeout();
      len = strobe_cnt - base;
   endtask

   task automatic check_rdata();
      logic [31:0] d;
      apb(1'b0, ebc_ready_pkg::rdata_offset, 32'h0, d);
      check(d, {16'h0, rd_word});
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic scen_reset();
      logic [31:0] d;
      logic r;
      check({29'h0, bus.cs_n, bus.rd_n, bus.wr_n}, 32'h7);
      // reference clock must move every system clock
      r = refclk;
      @(posedge pclk);
      check({31'h0, refclk}, {31'h0, ~r});
      apb(1'b0, ebc_ready_pkg::cfg_offset, 32'h0, d);
      check(d, ebc_ready_pkg::cfg_reset);
      apb(1'b0, ebc_ready_pkg::status_offset, 32'h0, d);
      // reset polarity is active low and the idle pin sits low: ready shows active
      check(d, 32'h2);
      apb(1'b0, 8'h18, 32'h0, d);
      check(d, 32'h0);
      check({31'h0, last_err}, 32'h0);
   endtask

   task automatic scen_waits();
      int l1, l2;
      run(cfg_of(5'd0, 1'b0, 1'b1, 1'b1), 1'b0, 8'd4, len_a);
      check_rdata();
      run(cfg_of(5'd0, 1'b0, 1'b1, 1'b1), 1'b0, 8'd5, l1);
      check(32'(l1 - len_a), 32'h1);
      run(cfg_of(5'd0, 1'b0, 1'b1, 1'b1), 1'b0, 8'd84, l1);
      check(32'(l1 - len_a), 32'd80);
      act_high <= 1'b0;
      run(cfg_of(5'd0, 1'b0, 1'b0, 1'b1), 1'b0, 8'd4, l1);
      check(32'(l1), 32'(len_a));
      act_high <= 1'b1;
      run(cfg_of(5'd5, 1'b0, 1'b1, 1'b1), 1'b0, 8'd0, l1);
      run(cfg_of(5'd31, 1'b0, 1'b1, 1'b1), 1'b0, 8'd0, l2);
      check(32'(l2 - l1), 32'd26);
   endtask

   task automatic scen_async();
      int l1;
      run(cfg_of(5'd0, 1'b1, 1'b1, 1'b1), 1'b0, 8'd4, l1);
      check(32'(l1 - len_a), 32'h1);
      link_mode <= 1'b1;
      run(cfg_of(5'd0, 1'b1, 1'b1, 1'b1), 1'b0, 8'd2, l1);
      check_rdata();
      link_mode <= 1'b0;
   endtask

   task automatic scen_write();
      int l1, l2;
      // longest setup, command, write setup and hold fields
      run(cfg_of(5'd2, 1'b0, 1'b1, 1'b0) | 32'h0000_0c1f, 1'b1, 8'd0, l1);
      check({16'h0, wr_seen}, 32'h0000_beef);
      check({8'h0, addr_seen}, 32'h0012_3456);
      run(cfg_of(5'd9, 1'b0, 1'b1, 1'b0) | 32'h0000_0c1f, 1'b1, 8'd0, l2);
      check(32'(l2 - l1), 32'd7);
   endtask

   task automatic scen_mux();
      int l1;
      // multiplexed write: the low address rides the data lines under ale
      run(cfg_of(5'd0, 1'b0, 1'b1, 1'b0) | 32'h0000_8000, 1'b1, 8'd0, l1);
      check({16'h0, mux_addr}, 32'h0000_3456);
      check(32'(l1), 32'h1);
   endtask

   initial begin
      pclk = 1'b0;
      lclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      act_high = 1'b1;
      link_mode = 1'b0;
      delay = 8'h00;
      failures = 0;
      checks_done = 0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      scen_reset();
      scen_waits();
      scen_async();
      scen_write();
      scen_mux();
      give_verdict();
   end
endmodule
